// *** core_exec.sv ***
// Core executing data moves, table reads, bit operations and jumps
// Functional notes
// RL1: Accumulator is sole endpoint of external data
// RL2: Ri 8-bit and pointer 16-bit, read/write
// RL3: Data strobes active only during external moves
// RL4: Table reads only read program memory
// RL5: External table read uses program read strobe
// RL6: Pointer table read fetches pointer plus accumulator
// RL7: Counter table read adds accumulator to next address
// RL8: Both table reads take two machine cycles
// RL9: Bit addresses map low RAM then registers
// RL10: Every port line is bit addressable
// RL11: Carry is bit accumulator, status bits addressable
// RL12: AND/OR with carry, two cycles, no XOR
// RL13: Bit to carry, set/clear/invert one cycle
// RL14: Bit-test branches; test-and-clear clears set bit
// RL15: Relative offset signed, from following instruction
// RL16: Short relative jump is two bytes
// RL17: Long jump three bytes, full 16-bit target
// RL18: Page jump replaces low 11 counter bits
// RL19: Indirect jump targets pointer plus accumulator
// RL20: Long call and in-page call exist
// RL21: Return resumes after the originating call
// RL22: Interrupt return also signals interrupt done
// RL23: Machine cycle is twelve oscillator periods
// RL24: No program fetch in external move second cycle
// RL25: Stack push increments pointer, then writes
// RL26: Call pushes low then high, return reverses
`timescale 1ns/1ps
`default_nettype none
module core_exec
  import core_exec_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset,
  // Program memory
  input  wire logic [7:0]      prog_data,
  output var  prog_bus_t       prog_bus,
  // External data memory
  input  wire logic [7:0]      xd_rdata,
  output var  xd_bus_t         xd_bus,
  // Port pins and latches
  input  wire logic [3:0][7:0] port_in,
  output var  logic [3:0][7:0] port_out,
  // Interrupt controller
  output var  logic            irq_done
);
  if (MCYC_SHORT != 1 || MCYC_LONG != 2 || PHASES_PER_MCYC != 12) begin : g_chk
    $error("core_exec: timing constants unsupported");
  end

  core_state_t st;
  core_state_t next_st;
  logic [3:0]  phase;
  logic [2:0]  shape;
  logic        long_op, first, exec, is_xd, is_tbl, cy, bval;
  logic [7:0]  ri_val, bbyte, bpin, blat, bnew;
  logic [7:0]  stk_up1, stk_up2, stk_dn1, stk_dn2;
  logic [15:0] xd_addr, tbl_addr, rel_op1, rel_op2, return_addr;
  mcyc_timer u_mcyc_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .phase    (phase)
  );
  // Length in bytes and long (two machine cycle) flag
  function automatic logic [2:0] op_shape(input logic [7:0] op);
    logic [2:0] r;
    r = {2'h1, 1'b0};
    if (op[3:0] == PAGE_LOW) begin
      r = {2'h2, 1'b1};
    end else begin
      case (op)
        8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3,
        OP_TABLE_DP, OP_TABLE_PGM, OP_JUMP_IND, OP_SUB_RETURN, OP_IRQ_RETURN: r = {2'h1, 1'b1};
        OP_AND_C_BIT, OP_AND_C_NBIT, OP_OR_C_BIT, OP_OR_C_NBIT, OP_BIT_FROM_C,
        OP_JUMP_ON_CARRY, OP_JUMP_ON_NO_CARRY, OP_SHORT_REL_JUMP: r = {2'h2, 1'b1};
        OP_C_FROM_BIT, OP_CLEAR_BIT, OP_SET_BIT, OP_INV_BIT, OP_LOAD_A: r = {2'h2, 1'b0};
        OP_JUMP_ON_BIT, OP_JUMP_ON_NO_BIT, OP_JUMP_AND_CLEAR_BIT, OP_LONG_JUMP,
        OP_LONG_CALL, OP_LOAD_DP, OP_LOAD_DIRECT: r = {2'h3, 1'b1};
        default: r = {2'h1, 1'b0};
      endcase
    end
    return r;
  endfunction
  // Byte holding a bit address
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'h0} : BIT_RAM_BASE + {4'h0, b[6:3]};
  endfunction
  function automatic logic [7:0] rd_byte(input core_state_t s, input logic [7:0] a,
                                         input logic [3:0][7:0] pins, input logic use_pins);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7]) begin
      v = s.ram[a[6:0]];
    end else begin
      case (a)
        REG_P0, REG_P1, REG_P2, REG_P3: v = use_pins ? pins[a[5:4]] : s.port_latch[a[5:4]];
        REG_STACK: v = s.stack_pointer;
        REG_DP_LO: v = s.data_pointer[7:0];
        REG_DP_HI: v = s.data_pointer[15:8];
        REG_STATUS: v = s.status_word;
        REG_ACC: v = s.acc;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  function automatic core_state_t wr_byte(input core_state_t s, input logic [7:0] a,
                                          input logic [7:0] v);
    core_state_t r;
    r = s;
    if (!a[7]) begin
      r.ram[a[6:0]] = v;
    end else begin
      case (a)
        REG_P0, REG_P1, REG_P2, REG_P3: r.port_latch[a[5:4]] = v;
        REG_STACK: r.stack_pointer = v;
        REG_DP_LO: r.data_pointer[7:0] = v;
        REG_DP_HI: r.data_pointer[15:8] = v;
        REG_STATUS: r.status_word = v;
        REG_ACC: r.acc = v;
        default: r = s;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    shape       = op_shape(st.opcode);
    long_op     = shape[0];
    first       = (st.mcyc == first_cycle);
    exec        = (phase == PH_LAST) && (long_op ? !first : first);
    is_xd       = (st.opcode[7:5] == XD_GROUP) && (st.opcode[3:2] == 2'h0) && (st.opcode[1:0] != 2'h1);
    is_tbl      = (st.opcode == OP_TABLE_DP) || (st.opcode == OP_TABLE_PGM);
    ri_val      = st.ram[{2'h0, st.status_word[BANK_HI:BANK_LO], 2'h0, st.opcode[0]}];
    xd_addr     = st.opcode[1] ? {st.port_latch[2], ri_val} : st.data_pointer; // RL2
    tbl_addr    = (st.opcode == OP_TABLE_DP ? st.data_pointer : st.program_counter)
                  + {8'h00, st.acc}; // RL6 RL7
    rel_op1     = st.program_counter + {{8{st.op1[7]}}, st.op1}; // RL15
    rel_op2     = st.program_counter + {{8{st.op2[7]}}, st.op2}; // RL15
    bbyte       = bit_byte(st.op1); // RL9
    bpin        = rd_byte(st, bbyte, port_in, 1'b1);
    blat        = rd_byte(st, bbyte, port_in, 1'b0);
    bval        = bpin[st.op1[2:0]];
    bnew        = blat;
    cy          = st.status_word[CY_POS]; // RL11
    stk_up1     = st.stack_pointer + 8'h01;
    stk_up2     = st.stack_pointer + 8'h02;
    stk_dn1     = st.stack_pointer - 8'h01;
    stk_dn2     = st.stack_pointer - 8'h02;
    return_addr = {st.ram[st.stack_pointer[6:0]], st.ram[stk_dn1[6:0]]}; // RL26
    next_st          = st;
    next_st.irq_done = 1'b0;
    case (phase)
      PH_S1_SET: begin
        if (first || !is_xd) begin // RL24
          next_st.prog.addr = (!first && is_tbl) ? tbl_addr : st.program_counter; // RL5
          next_st.prog.program_read_strobe = 1'b1;
        end
      end
      PH_S1_CAP: begin
        next_st.prog.program_read_strobe = 1'b0;
        if (first) begin
          next_st.opcode          = prog_data;
          next_st.program_counter = st.program_counter + 16'h0001;
        end else if (is_tbl) begin
          next_st.acc = prog_data; // RL4 RL6 RL7
        end else if (is_xd) begin
          next_st.xd.addr      = xd_addr; // RL2
          next_st.xd.wdata     = st.acc; // RL1
          next_st.xd.rd_strobe = !st.opcode[4]; // RL3
          next_st.xd.wr_strobe = st.opcode[4]; // RL3
        end else if (shape[2:1] == 2'h3) begin
          next_st.op2             = prog_data; // RL17
          next_st.program_counter = st.program_counter + 16'h0001;
        end
      end
      PH_S4_SET: begin
        if (first || !is_xd) begin // RL24
          next_st.prog.addr = st.program_counter;
          next_st.prog.program_read_strobe = 1'b1;
        end
      end
      PH_S4_CAP: begin
        next_st.prog.program_read_strobe = 1'b0;
        if (first && shape[2:1] != 2'h1) begin
          next_st.op1             = prog_data; // RL16
          next_st.program_counter = st.program_counter + 16'h0001;
        end
        if (!first && is_xd && st.xd.rd_strobe) begin
          next_st.acc = xd_rdata; // RL1
        end
        next_st.xd.rd_strobe = 1'b0; // RL3
        next_st.xd.wr_strobe = 1'b0; // RL3
      end
      PH_LAST: begin
        next_st.mcyc = (long_op && first) ? second_cycle : first_cycle; // RL8
        if (exec) begin
          if (st.opcode == OP_LONG_CALL || (st.opcode[3:0] == PAGE_LOW && st.opcode[4])) begin
            next_st.ram[stk_up1[6:0]] = st.program_counter[7:0]; // RL25 RL26
            next_st.ram[stk_up2[6:0]] = st.program_counter[15:8]; // RL25 RL26
            next_st.stack_pointer     = stk_up2; // RL20
          end
          if (st.opcode[3:0] == PAGE_LOW) begin
            next_st.program_counter = {st.program_counter[15:11], st.opcode[7:5], st.op1}; // RL18 RL20
          end else begin
            case (st.opcode)
              OP_AND_C_BIT: next_st.status_word[CY_POS] = cy & bval; // RL12
              OP_AND_C_NBIT: next_st.status_word[CY_POS] = cy & ~bval; // RL12
              OP_OR_C_BIT: next_st.status_word[CY_POS] = cy | bval; // RL12
              OP_OR_C_NBIT: next_st.status_word[CY_POS] = cy | ~bval; // RL12
              OP_C_FROM_BIT: next_st.status_word[CY_POS] = bval; // RL13
              OP_CLEAR_C: next_st.status_word[CY_POS] = 1'b0; // RL13
              OP_SET_C: next_st.status_word[CY_POS] = 1'b1; // RL13
              OP_INV_C: next_st.status_word[CY_POS] = ~cy; // RL13
              OP_BIT_FROM_C, OP_CLEAR_BIT, OP_SET_BIT, OP_INV_BIT: begin
                case (st.opcode)
                  OP_BIT_FROM_C: bnew[st.op1[2:0]] = cy;
                  OP_CLEAR_BIT: bnew[st.op1[2:0]] = 1'b0;
                  OP_SET_BIT: bnew[st.op1[2:0]] = 1'b1;
                  default: bnew[st.op1[2:0]] = ~blat[st.op1[2:0]];
                endcase
                next_st = wr_byte(next_st, bbyte, bnew); // RL10 RL11 RL13
              end
              OP_JUMP_ON_CARRY: if (cy) next_st.program_counter = rel_op1; // RL14
              OP_JUMP_ON_NO_CARRY: if (!cy) next_st.program_counter = rel_op1; // RL14
              OP_JUMP_ON_BIT: if (bval) next_st.program_counter = rel_op2; // RL14
              OP_JUMP_ON_NO_BIT: if (!bval) next_st.program_counter = rel_op2; // RL14
              OP_JUMP_AND_CLEAR_BIT: begin
                if (blat[st.op1[2:0]]) begin
                  bnew[st.op1[2:0]]       = 1'b0;
                  next_st                 = wr_byte(next_st, bbyte, bnew); // RL14
                  next_st.program_counter = rel_op2; // RL14
                end
              end
              OP_SHORT_REL_JUMP: next_st.program_counter = rel_op1; // RL15 RL16
              OP_LONG_JUMP, OP_LONG_CALL: next_st.program_counter = {st.op1, st.op2}; // RL17 RL20
              OP_JUMP_IND: next_st.program_counter = st.data_pointer + {8'h00, st.acc}; // RL19
              OP_SUB_RETURN, OP_IRQ_RETURN: begin
                next_st.program_counter = return_addr; // RL21 RL26
                next_st.stack_pointer   = stk_dn2; // RL26
                next_st.irq_done        = (st.opcode == OP_IRQ_RETURN); // RL22
              end
              OP_LOAD_A: next_st.acc = st.op1;
              OP_LOAD_DP: next_st.data_pointer = {st.op1, st.op2};
              OP_LOAD_DIRECT: next_st = wr_byte(next_st, st.op1, st.op2);
              default: next_st.acc = st.acc;
            endcase
          end
        end
      end
      default: next_st.irq_done = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= core_reset();
    end else begin
      st <= next_st;
    end
  end

  assign prog_bus = st.prog;
  assign xd_bus   = st.xd;
  assign port_out = st.port_latch;
  assign irq_done = st.irq_done;

  sequence s_xd_second;
    (st.mcyc == second_cycle) && is_xd;
  endsequence
  sequence s_table_start;
    (st.mcyc == first_cycle) && (phase == 4'h3) && is_tbl;
  endsequence
  property p_xd_wdata;
    @(posedge core_clk) disable iff (reset)
    st.xd.wr_strobe |-> (st.xd.wdata == st.acc);
  endproperty
  a_xd_wdata: assert property (p_xd_wdata) else $error("write data is not accumulator"); // RL1
  property p_xd_read;
    @(posedge core_clk) disable iff (reset)
    (st.xd.rd_strobe && phase == PH_S4_CAP) |=> (st.acc == $past(xd_rdata)) && !st.xd.rd_strobe;
  endproperty
  a_xd_read: assert property (p_xd_read) else $error("read data not loaded"); // RL1
  property p_xd_only;
    @(posedge core_clk) disable iff (reset)
    (st.xd.rd_strobe || st.xd.wr_strobe) |-> s_xd_second;
  endproperty
  a_xd_only: assert property (p_xd_only) else $error("data strobe outside move"); // RL3
  property p_no_fetch;
    @(posedge core_clk) disable iff (reset)
    s_xd_second |-> !st.prog.program_read_strobe;
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch in move second cycle"); // RL24
  property p_table_time;
    @(posedge core_clk) disable iff (reset)
    s_table_start |-> !exec [*8] ##13 exec;
  endproperty
  a_table_time: assert property (p_table_time) else $error("table read length wrong"); // RL8
  property p_table_strobe;
    @(posedge core_clk) disable iff (reset)
    (is_tbl && st.mcyc == second_cycle && phase == PH_S1_CAP)
      |-> st.prog.program_read_strobe && (st.prog.addr == tbl_addr);
  endproperty
  a_table_strobe: assert property (p_table_strobe) else $error("table address wrong"); // RL5
  property p_bit_short;
    @(posedge core_clk) disable iff (reset)
    (first && phase == 4'h3 && (st.opcode == OP_CLEAR_C || st.opcode == OP_SET_BIT || st.opcode == OP_C_FROM_BIT))
      |-> ##8 (exec && st.mcyc == first_cycle);
  endproperty
  a_bit_short: assert property (p_bit_short) else $error("bit op not one cycle"); // RL13
  property p_return;
    @(posedge core_clk) disable iff (reset)
    (exec && (st.opcode == OP_SUB_RETURN || st.opcode == OP_IRQ_RETURN))
      |=> (st.program_counter == $past(return_addr)) && (st.stack_pointer == $past(stk_dn2));
  endproperty
  a_return: assert property (p_return) else $error("return address wrong"); // RL21
  property p_irq_done;
    @(posedge core_clk) disable iff (reset)
    irq_done |-> $past(exec) && ($past(st.opcode) == OP_IRQ_RETURN);
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("spurious interrupt done"); // RL22
  property p_call_push;
    @(posedge core_clk) disable iff (reset)
    (exec && st.opcode == OP_LONG_CALL)
      |=> (st.ram[st.stack_pointer[6:0]] == $past(st.program_counter[15:8]))
          && (st.program_counter == {$past(st.op1), $past(st.op2)});
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong"); // RL26
  property p_rel_jump;
    @(posedge core_clk) disable iff (reset)
    (exec && st.opcode == OP_SHORT_REL_JUMP) |=> (st.program_counter == $past(rel_op1));
  endproperty
  a_rel_jump: assert property (p_rel_jump) else $error("relative target wrong"); // RL15
endmodule // core_exec
`default_nettype wire

// *** core_exec_pkg.sv ***
// Constants, opcodes and state types for the bit, table and branch core
package core_exec_pkg;
  // Machine cycle: states of two oscillator periods each
  localparam int unsigned STATES_PER_MCYC   = 6;
  localparam int unsigned PERIODS_PER_STATE = 2;
  localparam int unsigned PHASES_PER_MCYC   = STATES_PER_MCYC * PERIODS_PER_STATE;
  // Instruction times at the reference oscillator
  localparam int unsigned MCYC_NS_AT_REF    = 1000;
  localparam int unsigned T_SHORT_NS        = 1000;
  localparam int unsigned T_LONG_NS         = 2000;
  localparam int unsigned MCYC_SHORT        = T_SHORT_NS / MCYC_NS_AT_REF;
  localparam int unsigned MCYC_LONG         = T_LONG_NS / MCYC_NS_AT_REF;

  // Phase slots within a machine cycle
  localparam logic [3:0] PH_S1_SET = 4'h0;
  localparam logic [3:0] PH_S1_CAP = 4'h2;
  localparam logic [3:0] PH_S4_SET = 4'h6;
  localparam logic [3:0] PH_S4_CAP = 4'h8;
  localparam logic [3:0] PH_LAST   = 4'hb;

  // Direct byte addresses
  localparam logic [7:0] BIT_RAM_BASE  = 8'h20;
  localparam logic [7:0] REG_P0        = 8'h80;
  localparam logic [7:0] REG_P1        = 8'h90;
  localparam logic [7:0] REG_P2        = 8'ha0;
  localparam logic [7:0] REG_P3        = 8'hb0;
  localparam logic [7:0] REG_STACK     = 8'h81;
  localparam logic [7:0] REG_DP_LO     = 8'h82;
  localparam logic [7:0] REG_DP_HI     = 8'h83;
  localparam logic [7:0] REG_STATUS    = 8'hd0;
  localparam logic [7:0] REG_ACC       = 8'he0;

  // Status word fields and reset values
  localparam int unsigned CY_POS    = 7;
  localparam int unsigned BANK_HI   = 4;
  localparam int unsigned BANK_LO   = 3;
  localparam logic [7:0]  STACK_RST = 8'h07;
  localparam logic [7:0]  PORT_RST  = 8'hff;

  // Opcodes
  localparam logic [2:0] XD_GROUP              = 3'h7;
  localparam logic [3:0] PAGE_LOW              = 4'h1;
  localparam logic [7:0] OP_TABLE_DP           = 8'h93;
  localparam logic [7:0] OP_TABLE_PGM          = 8'h83;
  localparam logic [7:0] OP_AND_C_BIT          = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT         = 8'hb0;
  localparam logic [7:0] OP_OR_C_BIT           = 8'h72;
  localparam logic [7:0] OP_OR_C_NBIT          = 8'ha0;
  localparam logic [7:0] OP_C_FROM_BIT         = 8'ha2;
  localparam logic [7:0] OP_BIT_FROM_C         = 8'h92;
  localparam logic [7:0] OP_CLEAR_C            = 8'hc3;
  localparam logic [7:0] OP_CLEAR_BIT          = 8'hc2;
  localparam logic [7:0] OP_SET_C              = 8'hd3;
  localparam logic [7:0] OP_SET_BIT            = 8'hd2;
  localparam logic [7:0] OP_INV_C              = 8'hb3;
  localparam logic [7:0] OP_INV_BIT            = 8'hb2;
  localparam logic [7:0] OP_JUMP_ON_CARRY      = 8'h40;
  localparam logic [7:0] OP_JUMP_ON_NO_CARRY   = 8'h50;
  localparam logic [7:0] OP_JUMP_ON_BIT        = 8'h20;
  localparam logic [7:0] OP_JUMP_ON_NO_BIT     = 8'h30;
  localparam logic [7:0] OP_JUMP_AND_CLEAR_BIT = 8'h10;
  localparam logic [7:0] OP_SHORT_REL_JUMP     = 8'h80;
  localparam logic [7:0] OP_LONG_JUMP          = 8'h02;
  localparam logic [7:0] OP_LONG_CALL          = 8'h12;
  localparam logic [7:0] OP_JUMP_IND           = 8'h73;
  localparam logic [7:0] OP_SUB_RETURN         = 8'h22;
  localparam logic [7:0] OP_IRQ_RETURN         = 8'h32;
  localparam logic [7:0] OP_LOAD_A             = 8'h74;
  localparam logic [7:0] OP_LOAD_DP            = 8'h90;
  localparam logic [7:0] OP_LOAD_DIRECT        = 8'h75;

  typedef enum logic {first_cycle, second_cycle} mcyc_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        program_read_strobe;
  } prog_bus_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd_strobe;
    logic        wr_strobe;
  } xd_bus_t;

  typedef struct packed {
    logic [3:0] phase;
  } timer_state_t;

  typedef struct packed {
    mcyc_t            mcyc;
    logic [7:0]       opcode;
    logic [7:0]       op1;
    logic [7:0]       op2;
    logic [7:0]       acc;
    logic [7:0]       status_word;
    logic [7:0]       stack_pointer;
    logic [15:0]      data_pointer;
    logic [15:0]      program_counter;
    logic [3:0][7:0]  port_latch;
    logic [127:0][7:0] ram;
    prog_bus_t        prog;
    xd_bus_t          xd;
    logic             irq_done;
  } core_state_t;

  function automatic core_state_t core_reset();
    core_state_t s;
    s               = '0;
    s.stack_pointer = STACK_RST;
    s.port_latch    = {4{PORT_RST}};
    return s;
  endfunction
endpackage

// *** mcyc_timer.sv ***
// Machine-cycle phase generator
`timescale 1ns/1ps
`default_nettype none
module mcyc_timer
  import core_exec_pkg::*;
#(
  parameter int unsigned STATES  = STATES_PER_MCYC,
  parameter int unsigned PERIODS = PERIODS_PER_STATE
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Phase within the machine cycle
  output var  logic [3:0] phase
);
  localparam logic [3:0] LAST = 4'(STATES * PERIODS - 1);

  if (STATES * PERIODS > 16 || STATES * PERIODS < 2) begin : g_chk
    $error("mcyc_timer: phase count out of range");
  end

  timer_state_t st;
  timer_state_t next_st;

  always_comb begin
    next_st       = st;
    next_st.phase = (st.phase == LAST) ? 4'h0 : st.phase + 4'h1; // RL23
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.phase;

  property p_phase_wrap;
    @(posedge core_clk) disable iff (reset)
    (phase == LAST) |=> (phase == 4'h0) ##11 (phase == LAST);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("machine cycle length wrong"); // RL23
endmodule // mcyc_timer
`default_nettype wire

// *** ext_mem_model.sv ***
// Program memory and external data RAM facing the core
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
  import core_exec_pkg::*;
(
  // Clock
  input  wire logic      core_clk,
  // Buses from the core
  input  wire prog_bus_t prog_bus,
  input  wire xd_bus_t   xd_bus,
  // Read data
  output logic [7:0]     prog_data,
  output logic [7:0]     xd_rdata
);
  logic [7:0] rom [0:65535];
  logic [7:0] ram [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      rom[i] = 8'h00;
      ram[i] = 8'h00;
    end
  end
  // Released bus shows inverted data
  assign prog_data = prog_bus.program_read_strobe ? rom[prog_bus.addr] : ~rom[prog_bus.addr];
  assign xd_rdata  = xd_bus.rd_strobe ? ram[xd_bus.addr] : ~ram[xd_bus.addr];
  always @(posedge core_clk) begin
    if (xd_bus.wr_strobe === 1'b1) ram[xd_bus.addr] <= xd_bus.wdata;
  end
endmodule // ext_mem_model
`default_nettype wire

// *** tb_cpu_branch_bit_table_exec.sv ***
// Self-checking bench for the bit, table and branch core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_cpu_branch_bit_table_exec;
  import core_exec_pkg::*;
  logic            core_clk = 1'b0;
  logic            reset    = 1'b1;
  logic [3:0][7:0] port_in  = '0;
  logic [7:0]      prog_data, xd_rdata;
  prog_bus_t       prog_bus;
  xd_bus_t         xd_bus;
  logic [3:0][7:0] port_out;
  logic            irq_done;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0, last_wr = 0, n_irq = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) cyc++;
  always @(negedge core_clk) begin
    if (irq_done === 1'b1) n_irq++;
  end
  core_exec u_core_exec (.core_clk(core_clk), .reset(reset), .prog_data(prog_data), .prog_bus(prog_bus),
    .xd_rdata(xd_rdata), .xd_bus(xd_bus), .port_in(port_in), .port_out(port_out), .irq_done(irq_done));
  ext_mem_model u_ext_mem_model (.core_clk(core_clk), .prog_bus(prog_bus), .xd_bus(xd_bus),
    .prog_data(prog_data), .xd_rdata(xd_rdata));

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic put(input logic [15:0] a, input logic [63:0] b, input int n);
    for (int i = 0; i < n; i++) u_ext_mem_model.rom[a + 16'(i)] = b[8*(n-1-i) +: 8];
  endtask
  task automatic clear();
    @(negedge core_clk);
    reset = 1'b1;
    for (int i = 0; i < 65536; i++) u_ext_mem_model.rom[i] = 8'h00;
  endtask
  task automatic go();
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    n_irq = 0;
    last_wr = cyc;
  endtask
  // Wait for a data write, check address, data and spacing
  task automatic wait_wr(input logic [15:0] a, input logic [7:0] d, input int gap);
    int k;
    k = 0;
    while (xd_bus.wr_strobe !== 1'b1 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 2000) begin
      n_mismatch++;
      print_verdict();
    end
    `CHK(prog_bus.program_read_strobe, 1'b0)
    `CHK(xd_bus.addr, a)
    `CHK(xd_bus.wdata, d)
    `CHK(xd_bus.rd_strobe, 1'b0)
    if (gap > 0) `CHK(cyc - last_wr, gap)
    last_wr = cyc;
    repeat (6) @(negedge core_clk);
    `CHK(xd_bus.wr_strobe, 1'b0)
  endtask

  task automatic t_table();
    clear();
    put(0, 64'h9012347405_93f0, 7);
    put(7, 64'h740283f0003c, 6);
    put(13, 64'h750040e2f0f2, 6);
    put(16'h1239, 64'h5a, 1);
    u_ext_mem_model.ram[16'hff40] = 8'h77;
    go();
    wait_wr(16'h1234, 8'h5a, 0);
    wait_wr(16'h1234, 8'h3c, 60);
    wait_wr(16'h1234, 8'h77, 0);
    wait_wr(16'hff40, 8'h77, 24);
    $display("Test table and data moves done");
  endtask
  task automatic t_bits();
    clear();
    port_in[1] = 8'h08;
    put(0, 64'hc39290b292a293b0, 8);
    put(8, 64'h9482957293a093b2, 8);
    put(16, 64'hd792961091_02c297, 8);
    put(24, 64'hf080fe, 3);
    go();
    wait_wr(16'h0000, 8'h00, 0);
    `CHK(port_out[1], 8'hb8)
    `CHK(port_out[0], 8'hff)
    $display("Test bit operations done");
  endtask
  task automatic t_jumps();
    clear();
    put(0, 64'h807f, 2);
    put(16'h0081, 64'h021200, 3);
    put(16'h1200, 64'h120800, 3);
    put(16'h0800, 64'h32, 1);
    put(16'h1203, 64'h7404900ff073, 6);
    put(16'h0ff4, 64'hf08080, 3);
    put(16'h0f77, 64'h7145, 2);
    put(16'h0b45, 64'h22, 1);
    put(16'h0f79, 64'h6150, 2);
    put(16'h0b50, 64'h7409f0, 3);
    go();
    wait_wr(16'h0ff0, 8'h04, 0);
    `CHK(n_irq, 1)
    wait_wr(16'h0ff0, 8'h09, 132);
    $display("Test jumps and calls done");
  endtask
  task automatic t_cond();
    clear();
    port_in[1] = 8'h01;
    put(0, 64'h7411d3400274ee50, 8);
    put(8, 64'h0220900274ee3090, 8);
    put(16, 64'h0230910274eeb350, 8);
    put(24, 64'h0274eed2d7400274, 8);
    put(32, 64'heec297f07422e0f3, 8);
    put(40, 64'h80fe, 2);
    go();
    wait_wr(16'h0000, 8'h11, 0);
    wait_wr(16'hff00, 8'h11, 60);
    `CHK(port_out[1], 8'h7f)
    $display("Test conditional jumps done");
  endtask

  initial begin
    t_table();
    t_bits();
    t_jumps();
    t_cond();
    print_verdict();
  end
endmodule // tb_cpu_branch_bit_table_exec
`default_nettype wire
